// ### dacpc_pkg.sv
// Package for the converter pair control block: offsets, fields, reset values.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package dacpc_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] DACPC_OFF_CFG0_0   = 8'h00;
	localparam logic [7:0] DACPC_OFF_CFG0_1   = 8'h04;
	localparam logic [7:0] DACPC_OFF_CFG0_2   = 8'h08;
	localparam logic [7:0] DACPC_OFF_CFG0_3   = 8'h0c;
	localparam logic [7:0] DACPC_OFF_CFG1_0   = 8'h10;
	localparam logic [7:0] DACPC_OFF_CFG1_1   = 8'h14;
	localparam logic [7:0] DACPC_OFF_CFG1_2   = 8'h18;
	localparam logic [7:0] DACPC_OFF_CFG1_3   = 8'h1c;
	localparam logic [7:0] DACPC_OFF_LOW_0    = 8'h20;
	localparam logic [7:0] DACPC_OFF_HIGH_0   = 8'h30;
	localparam logic [7:0] DACPC_OFF_GCFG0    = 8'h40;
	localparam logic [7:0] DACPC_OFF_GCFG2    = 8'h44;
	localparam logic [7:0] DACPC_OFF_STATUS   = 8'h48;

	// ==========================================================
	// Field positions
	localparam int DACPC_CFG0_EN       = 0;
	localparam int DACPC_CFG0_PERSIST  = 1;
	localparam int DACPC_GCFG0_REF01   = 3;
	localparam int DACPC_GCFG0_REF23   = 7;
	localparam int DACPC_GCFG2_ATT01   = 0;
	localparam int DACPC_GCFG2_ATT23   = 4;

	// ==========================================================
	// Reset values and codes
	localparam logic [1:0] DACPC_GAIN_RST     = 2'h0;
	localparam logic [1:0] DACPC_GAIN_MAX     = 2'h2;
	localparam logic       DACPC_REF01_RST    = 1'b0;
	localparam logic       DACPC_REF23_RST    = 1'b1;
	localparam logic [11:0] DACPC_CODE_RST    = 12'h000;
	localparam int          DACPC_NUM_CONV    = 4;
	localparam int          DACPC_CODE_W      = 12;

endpackage : dacpc_pkg

// ### dacpc_channel.sv
// One converter channel: enable, persist, gain, data latches with inhibit.
// Assumes pclk domain; system reset supplied by the parent, qualified by persist here.
`timescale 1ns/10ps
`default_nettype none
module dacpc_channel
	import dacpc_pkg::*;
#(
	parameter int CODE_W = DACPC_CODE_W
) (
	input  wire logic              pclk,
	input  wire logic              por_n,
	input  wire logic              sys_rst,
	input  wire logic              wr_cfg0,
	input  wire logic              wr_cfg1,
	input  wire logic              wr_low,
	input  wire logic              wr_high,
	input  wire logic [7:0]        wdata,
	output logic                   enable,
	output logic                   persist,
	output logic [1:0]             gain_code,
	output logic [1:0]             gain_eff,
	output logic [CODE_W-1:0]      code_in,
	output logic [CODE_W-1:0]      code_out,
	output logic                   inhibit
);

	// ==========================================================
	// Reset qualifier: persist keeps state over system reset
	logic clr;
	assign clr = sys_rst && !persist;

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			persist <= 1'b0;
		end else if (clr) begin
			persist <= 1'b0;
		end else if (wr_cfg0) begin
			persist <= wdata[DACPC_CFG0_PERSIST];
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			enable <= 1'b0;
		end else if (clr) begin
			enable <= 1'b0;
		end else if (wr_cfg0) begin
			enable <= wdata[DACPC_CFG0_EN];
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			gain_code <= DACPC_GAIN_RST;
		end else if (clr) begin
			gain_code <= DACPC_GAIN_RST;
		end else if (wr_cfg1) begin
			gain_code <= wdata[1:0];
		end
	end

	// undefined code maps to highest legal
	logic [1:0] next_gain_eff;
	assign next_gain_eff = (wdata[1:0] > DACPC_GAIN_MAX) ? DACPC_GAIN_MAX : wdata[1:0];

	// Effective gain held in a flop for the analog side
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			gain_eff <= DACPC_GAIN_RST;
		end else if (clr) begin
			gain_eff <= DACPC_GAIN_RST;
		end else if (wr_cfg1) begin
			gain_eff <= next_gain_eff;
		end
	end

	// low then high, low inhibits update
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			code_in <= DACPC_CODE_RST;
			inhibit <= 1'b0;
		end else if (clr) begin
			code_in <= DACPC_CODE_RST;
			inhibit <= 1'b0;
		end else if (wr_low) begin
			code_in[7:0] <= wdata;
			inhibit      <= 1'b1;
		end else if (wr_high) begin
			code_in[CODE_W-1:8] <= wdata[CODE_W-9:0];
			inhibit             <= 1'b0;
		end
	end

	// static output latch, updates after high byte
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			code_out <= DACPC_CODE_RST;
		end else if (clr) begin
			code_out <= DACPC_CODE_RST;
		end else if (wr_high) begin
			code_out <= {wdata[CODE_W-9:0], code_in[7:0]};
		end
	end

endmodule : dacpc_channel
`default_nettype wire

// ### dacpc_top.sv
// Top of the converter pair control block with its APB register file.
// Assumes APB master on pclk; por_n is an asynchronous power-on reset,
// presetn the ordinary system reset (both active low).
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module dacpc_top
	import dacpc_pkg::*;
#(
	parameter int NUM_CONV = DACPC_NUM_CONV,
	parameter int CODE_W   = DACPC_CODE_W
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         por_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	output logic [NUM_CONV-1:0]               conv_enable,
	output logic [NUM_CONV*CODE_W-1:0]        conv_code,
	output logic [NUM_CONV*2-1:0]             conv_gain,
	output logic                              pair01_ref_select,
	output logic                              pair23_ref_select,
	output logic [1:0]                        pair01_ref_atten,
	output logic [1:0]                        pair23_ref_atten,
	output logic [NUM_CONV-1:0]               update_inhibit
);

	// ==========================================================
	// System reset: presetn synchronised, por_n async
	logic rst_meta;
	logic rst_sync;
	logic sys_rst;
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			rst_meta <= 1'b1;
			rst_sync <= 1'b1;
		end else begin
			rst_meta <= ~presetn;
			rst_sync <= rst_meta;
		end
	end
	assign sys_rst = rst_sync;

	// ==========================================================
	// APB decode
	logic                wr_acc;
	logic                rd_setup;
	logic [5:0]          widx;
	logic                addr_ok;
	logic [NUM_CONV-1:0] sel_cfg0;
	logic [NUM_CONV-1:0] sel_cfg1;
	logic [NUM_CONV-1:0] sel_low;
	logic [NUM_CONV-1:0] sel_high;
	logic                sel_gcfg0;
	logic                sel_gcfg2;
	logic                sel_status;
	logic [NUM_CONV-1:0] wr_cfg0;
	logic [NUM_CONV-1:0] wr_cfg1;
	logic [NUM_CONV-1:0] wr_low;
	logic [NUM_CONV-1:0] wr_high;
	logic                wr_gcfg0;
	logic                wr_gcfg2;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign widx     = paddr[7:2];
	// Zero wait: read data is registered in the setup cycle
	assign pready   = 1'b1;

	// Register selects, one per word of the map
	always_comb begin
		sel_cfg0 = '0;
		sel_cfg1 = '0;
		sel_low  = '0;
		sel_high = '0;
		for (int n = 0; n < NUM_CONV; n++) begin
			sel_cfg0[n] = (paddr == DACPC_OFF_CFG0_0 + 8'(4 * n));
			sel_cfg1[n] = (paddr == DACPC_OFF_CFG1_0 + 8'(4 * n));
			sel_low[n]  = (paddr == DACPC_OFF_LOW_0 + 8'(4 * n));
			sel_high[n] = (paddr == DACPC_OFF_HIGH_0 + 8'(4 * n));
		end
	end
	assign sel_gcfg0  = (paddr == DACPC_OFF_GCFG0);
	assign sel_gcfg2  = (paddr == DACPC_OFF_GCFG2);
	assign sel_status = (paddr == DACPC_OFF_STATUS);

	// Unmapped or misaligned word: error response, no effect
	assign addr_ok = (|sel_cfg0) || (|sel_cfg1) || (|sel_low) || (|sel_high)
		|| sel_gcfg0 || sel_gcfg2 || sel_status;
	assign pslverr = psel && penable && !addr_ok;

	// write strobes, valid only in the access cycle
	assign wr_cfg0  = sel_cfg0 & {NUM_CONV{wr_acc}};
	assign wr_cfg1  = sel_cfg1 & {NUM_CONV{wr_acc}};
	assign wr_low   = sel_low & {NUM_CONV{wr_acc}};
	assign wr_high  = sel_high & {NUM_CONV{wr_acc}};
	assign wr_gcfg0 = sel_gcfg0 && wr_acc;
	assign wr_gcfg2 = sel_gcfg2 && wr_acc;

	// ==========================================================
	// Channels
	logic [NUM_CONV-1:0]        ch_persist;
	logic [NUM_CONV*2-1:0]      ch_gain_code;
	logic [NUM_CONV*CODE_W-1:0] ch_code_in;

	genvar g;
	generate
		for (g = 0; g < NUM_CONV; g++) begin : g_ch
			logic wc0;
			logic wc1;
			logic wlo;
			logic whi;
			assign wc0 = wr_cfg0[g];
			assign wc1 = wr_cfg1[g];
			assign wlo = wr_low[g];
			assign whi = wr_high[g];
			dacpc_channel #(
				.CODE_W (CODE_W)
			) u_ch (
				.pclk      (pclk),
				.por_n     (por_n),
				.sys_rst   (sys_rst),
				.wr_cfg0   (wc0),
				.wr_cfg1   (wc1),
				.wr_low    (wlo),
				.wr_high   (whi),
				.wdata     (pwdata[7:0]),
				.enable    (conv_enable[g]),
				.persist   (ch_persist[g]),
				.gain_code (ch_gain_code[2*g +: 2]),
				.gain_eff  (conv_gain[2*g +: 2]),
				.code_in   (ch_code_in[CODE_W*g +: CODE_W]),
				.code_out  (conv_code[CODE_W*g +: CODE_W]),
				.inhibit   (update_inhibit[g])
			);
		end
	endgenerate

	// ==========================================================
	// Pair settings: keep over system reset if both pair members persist
	logic        keep01;
	logic        keep23;
	logic [1:0]  att01_code;
	logic [1:0]  att23_code;
	assign keep01 = ch_persist[0] && ch_persist[1];
	assign keep23 = ch_persist[2] && ch_persist[3];

	// pair 0/1 reference select, resets to pin
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pair01_ref_select <= DACPC_REF01_RST;
		end else if (sys_rst && !keep01) begin
			pair01_ref_select <= DACPC_REF01_RST;
		end else if (wr_gcfg0) begin
			pair01_ref_select <= pwdata[DACPC_GCFG0_REF01];
		end
	end

	// pair 2/3 select resets to supply
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pair23_ref_select <= DACPC_REF23_RST;
		end else if (sys_rst && !keep23) begin
			pair23_ref_select <= DACPC_REF23_RST;
		end else if (wr_gcfg0) begin
			pair23_ref_select <= pwdata[DACPC_GCFG0_REF23];
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			att01_code <= DACPC_GAIN_RST;
		end else if (sys_rst && !keep01) begin
			att01_code <= DACPC_GAIN_RST;
		end else if (wr_gcfg2) begin
			att01_code <= pwdata[DACPC_GCFG2_ATT01 +: 2];
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			att23_code <= DACPC_GAIN_RST;
		end else if (sys_rst && !keep23) begin
			att23_code <= DACPC_GAIN_RST;
		end else if (wr_gcfg2) begin
			att23_code <= pwdata[DACPC_GCFG2_ATT23 +: 2];
		end
	end

	// clamp undefined attenuation, same code space as gain
	logic [1:0] next_att01_eff;
	logic [1:0] next_att23_eff;
	assign next_att01_eff = (pwdata[DACPC_GCFG2_ATT01 +: 2] > DACPC_GAIN_MAX) ? DACPC_GAIN_MAX
		: pwdata[DACPC_GCFG2_ATT01 +: 2];
	assign next_att23_eff = (pwdata[DACPC_GCFG2_ATT23 +: 2] > DACPC_GAIN_MAX) ? DACPC_GAIN_MAX
		: pwdata[DACPC_GCFG2_ATT23 +: 2];

	// Effective attenuation held in flops for the analog side
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pair01_ref_atten <= DACPC_GAIN_RST;
		end else if (sys_rst && !keep01) begin
			pair01_ref_atten <= DACPC_GAIN_RST;
		end else if (wr_gcfg2) begin
			pair01_ref_atten <= next_att01_eff;
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pair23_ref_atten <= DACPC_GAIN_RST;
		end else if (sys_rst && !keep23) begin
			pair23_ref_atten <= DACPC_GAIN_RST;
		end else if (wr_gcfg2) begin
			pair23_ref_atten <= next_att23_eff;
		end
	end

	// ==========================================================
	// Read mux
	logic [31:0] next_prdata;
	logic [1:0]  ridx;
	always_comb begin
		next_prdata = 32'h0000_0000;
		ridx        = widx[1:0];
		case (widx)
			6'h00, 6'h01, 6'h02, 6'h03: begin
				next_prdata = {30'h0, ch_persist[ridx], conv_enable[ridx]};
			end
			6'h04, 6'h05, 6'h06, 6'h07: begin
				next_prdata = {30'h0, ch_gain_code[2*ridx +: 2]};
			end
			// every data register readable, any enable
			6'h08, 6'h09, 6'h0a, 6'h0b: begin
				next_prdata = {24'h0, ch_code_in[CODE_W*ridx +: 8]};
			end
			6'h0c, 6'h0d, 6'h0e, 6'h0f: begin
				next_prdata = {28'h0, ch_code_in[CODE_W*ridx + 8 +: 4]};
			end
			6'h10: begin
				next_prdata = {24'h0, pair23_ref_select, 3'h0, pair01_ref_select, 3'h0};
			end
			6'h11: begin
				next_prdata = {26'h0, att23_code, 2'h0, att01_code};
			end
			6'h12: begin
				next_prdata = {28'h0, update_inhibit};
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data captured in the setup cycle; zero otherwise and for bad words
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup && addr_ok) begin
			prdata <= next_prdata;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

endmodule : dacpc_top
`default_nettype wire

// ### dacpc_properties.sv
// Register-effect checker for dacpc_top.
// Sees only the top ports; bound below.
`timescale 1ns/10ps
`default_nettype none
module dacpc_properties
	import dacpc_pkg::*;
#(
	parameter int NUM_CONV = DACPC_NUM_CONV,
	parameter int CODE_W   = DACPC_CODE_W
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  por_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [NUM_CONV-1:0]   conv_enable,
	input wire logic [NUM_CONV*CODE_W-1:0] conv_code,
	input wire logic [NUM_CONV*2-1:0] conv_gain,
	input wire logic                  pair01_ref_select,
	input wire logic                  pair23_ref_select,
	input wire logic [1:0]            pair01_ref_atten,
	input wire logic [1:0]            pair23_ref_atten,
	input wire logic [NUM_CONV-1:0]   update_inhibit
);
	// ============
	// Helpers
	wire logic hi_wr = psel && penable && pwrite && paddr[7:4] == 4'h3;
	default clocking @(posedge pclk); endclocking
	default disable iff (!por_n || !presetn);
	function automatic logic [1:0] clamp(input logic [1:0] c);
		return (c == 2'h3) ? DACPC_GAIN_MAX : c;
	endfunction : clamp
	sequence s_wr(logic [7:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence s_low_high;
		s_wr(DACPC_OFF_LOW_0 + 8'h0c) ##[1:20] s_wr(DACPC_OFF_HIGH_0 + 8'h0c);
	endsequence
	// ============
	// Assertions
	AST_ENABLE: assert property (
		s_wr(DACPC_OFF_CFG0_0) |=> conv_enable[0] == $past(pwdata[0])) else $error("enable");
	AST_GAIN: assert property (
		s_wr(DACPC_OFF_CFG1_3) |=> conv_gain[7:6] == clamp($past(pwdata[1:0]))) else $error("gain");
	AST_REFSEL: assert property (
		s_wr(DACPC_OFF_GCFG0) |=> pair01_ref_select == $past(pwdata[3])
		&& pair23_ref_select == $past(pwdata[7])) else $error("ref select");
	AST_ATTEN: assert property (
		s_wr(DACPC_OFF_GCFG2) |=> pair01_ref_atten == clamp($past(pwdata[1:0]))
		&& pair23_ref_atten == clamp($past(pwdata[5:4]))) else $error("atten");
	AST_INHIBIT: assert property (
		s_wr(DACPC_OFF_LOW_0 + 8'h0c) |=> update_inhibit[3] && $stable(conv_code))
		else $error("inhibit");
	AST_LOAD: assert property (
		s_low_high |=> !update_inhibit[3] && conv_code[47:44] == $past(pwdata[3:0]))
		else $error("load");
	AST_CODE_HOLD: assert property (
		$changed(conv_code) |-> $past(hi_wr)) else $error("code moved");
	AST_SLVERR: assert property (
		psel && penable |-> pready && pslverr == (paddr[1:0] != 2'h0
		|| paddr > DACPC_OFF_STATUS)) else $error("slverr");
	AST_RD_ZERO: assert property (
		psel && penable && !pwrite && pslverr |-> prdata == 32'h0) else $error("rdata");
endmodule : dacpc_properties
bind dacpc_top dacpc_properties #(.NUM_CONV(NUM_CONV), .CODE_W(CODE_W)) chk_u (
	.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .conv_enable(conv_enable), .conv_code(conv_code),
	.conv_gain(conv_gain), .pair01_ref_select(pair01_ref_select),
	.pair23_ref_select(pair23_ref_select), .pair01_ref_atten(pair01_ref_atten),
	.pair23_ref_atten(pair23_ref_atten), .update_inhibit(update_inhibit));
`default_nettype wire

// ### dacpc_tb_top.sv
// Self-checking bench for dacpc_top.
// Drives APB and both resets directly.
`timescale 1ns/10ps
`default_nettype none
module dacpc_tb_top
	import dacpc_pkg::*;
;
	logic        pclk = 0, presetn = 0, por_n = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, p01s, p23s;
	logic [3:0]  en, inh;
	logic [47:0] code;
	logic [7:0]  gain;
	logic [1:0]  a01, a23;
	int          n_errors = 0, checks = 0;
	always #5 pclk = ~pclk;
	dacpc_top dut_u (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_enable(en),
		.conv_code(code), .conv_gain(gain), .pair01_ref_select(p01s),
		.pair23_ref_select(p23s), .pair01_ref_atten(a01), .pair23_ref_atten(a23),
		.update_inhibit(inh));
	// ============
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= (w != 0);
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin
			n_errors++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	task automatic pulse(input bit por);
		@(posedge pclk);
		if (por) por_n <= 1'b0;
		else presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		por_n <= 1'b1;
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
	endtask : pulse
	// ============
	// Scenarios
	task automatic t_rst;
		apb(0, DACPC_OFF_GCFG0, 0);
		chk(rd, 32'h80);
		chk({p23s, p01s, en, inh}, 10'h200);
	endtask : t_rst
	task automatic t_gain;
		for (int c = 0; c < 4; c++) begin
			apb(1, DACPC_OFF_CFG1_3, c);
			chk(gain[7:6], c == 3 ? 2 : c);
			apb(0, DACPC_OFF_CFG1_3, 0);
			chk(rd, c);
			apb(1, DACPC_OFF_GCFG2, c * 17);
			chk({a23, a01}, c == 3 ? 4'ha : 4'(c * 5));
		end
	endtask : t_gain
	task automatic t_en;
		for (int n = 0; n < 4; n++) begin
			apb(1, DACPC_OFF_CFG0_0 + 8'(4 * n), 1);
			chk(en, (32'h2 << n) - 1);
		end
	endtask : t_en
	task automatic t_ref;
		apb(1, DACPC_OFF_GCFG0, 32'h08);
		chk({p23s, p01s}, 2'b01);
		apb(1, DACPC_OFF_GCFG0, 32'h80);
		chk({p23s, p01s}, 2'b10);
	endtask : t_ref
	task automatic t_data;
		apb(1, DACPC_OFF_LOW_0 + 8'hc, 32'hcd);
		chk({inh, code[47:36]}, 16'h8000);
		apb(0, DACPC_OFF_STATUS, 0);
		chk(rd, 32'h8);
		apb(1, DACPC_OFF_HIGH_0 + 8'hc, 32'h7a);
		chk({inh, code[47:36]}, 16'h0acd);
	endtask : t_data
	task automatic t_bad;
		apb(1, 8'h41, 32'h0);
		chk({err, p23s}, 2'b11);
		apb(0, 8'h4c, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(0, 8'h41, 0);
		chk(rd, 32'h0);
	endtask : t_bad
	task automatic t_persist;
		apb(1, DACPC_OFF_CFG0_3, 32'h3);
		pulse(0);
		chk({en, code[47:36]}, 16'h8acd);
		pulse(1);
		chk({en, code[47:36], p23s}, 17'h1);
	endtask : t_persist
	// ============
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		repeat (3) @(posedge pclk);
		t_rst();
		t_gain();
		t_en();
		t_ref();
		t_data();
		t_bad();
		t_persist();
		wrap_up();
	end
endmodule : dacpc_tb_top
`default_nettype wire
